// ---- dv/iel_field.sv ----
// breaker aux contacts and device inhibit contact
`timescale 1ns/100ps
module iel_field (
    input  wire logic        i_closed_nc,
    input  wire logic [6:0]  i_closed,
    input  wire logic        i_inhibit_req,
    output iel_pkg::iel_brk_t o_breakers,
    output logic             o_contact
);
    import iel_pkg::*;
    // one aux contact per breaker, closed reads one
    assign o_breakers = iel_brk_t'(i_closed);
    // nc wiring opens the contact to inhibit
    assign o_contact = i_inhibit_req ^ i_closed_nc;
endmodule

// ---- dv/iel_top_bench.sv ----
// self-checking bench for the exclusion logic
`timescale 1ns/100ps
`include "iel_regs.svh"
module iel_top_bench;
    import iel_pkg::*;
    logic       i_clock;
    logic       i_rst;
    logic [6:0] closed;
    logic       nc_mode;
    logic       inh_req;
    logic       i_alarm;
    logic       i_prev_alarm;
    iel_bus_t   bus;
    iel_brk_t   brk;
    logic       contact;
    logic [7:0] rdata;
    logic [3:1] inhibit;
    logic       injecting;
    logic       relay;
    iel_view_t  view;
    logic       irq;
    logic [1:0] pol;
    logic       ack;
    logic       exp_inj;
    logic       exp_rel;
    logic [7:0] v;
    logic [6:0] pats[$];
    int         num_errors;
    int         cmp_count;
    iel_field u_iel_field (.i_closed_nc(nc_mode), .i_closed(closed), .i_inhibit_req(inh_req),
        .o_breakers(brk), .o_contact(contact));
    iel_top u_iel_top (.i_clock(i_clock), .i_rst(i_rst), .i_breakers(brk),
        .i_inhibit_contact(contact), .i_alarm(i_alarm), .i_prev_alarm(i_prev_alarm),
        .i_bus(bus), .o_rdata(rdata), .o_inhibit(inhibit), .o_injecting(injecting),
        .o_alarm_relay(relay), .o_view(view), .o_irq(irq));
    task automatic cmp(input string nm, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // path model: a bus reaches an earlier closed feeder through closed couplings
    function automatic logic [2:0] model_inh(input logic [6:0] cl);
        logic       reach;
        logic [2:0] r;
        reach = cl[0];
        r = 3'h0;
        for (int i = 1; i < 4; i++)
        begin
            r[i-1] = cl[i] & cl[i+3] & reach;
            reach = cl[i] | (cl[i+3] & reach);
        end
        return r;
    endfunction
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge i_clock);
        bus <= '{addr: a, wdata: d, wr: 1'h1, rd: 1'h0};
        @(posedge i_clock);
        bus <= '0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge i_clock);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'h0, rd: 1'h1};
        @(posedge i_clock);
        bus <= '0;
        #1 d = rdata;
    endtask
    // external type only: re-enable goes straight to the measure view
    task automatic check_state();
        repeat (8) @(posedge i_clock);
        exp_inj = pol[1] ? 1'h1 : (pol[0] ? contact : !contact);
        exp_rel = i_alarm | (ack & !exp_inj);
        cmp("injecting", exp_inj, injecting);
        cmp("relay", exp_rel, relay);
        cmp("view", {7'h0, !exp_inj}, view);
        cmp("inhibit", 8'h00, inhibit);
        rd(`IEL_ADDR_STAT, v);
        cmp("stat", {3'h0, i_prev_alarm, !exp_inj, exp_rel, 1'h0, !exp_inj}, v);
    endtask
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial
    begin
        i_clock = 1'h0;
        forever #2 i_clock = ~i_clock;
    end
    initial
    begin
        // tests need about 30k cycles; allow 50k
        #200000;
        num_errors++;
        test_done();
    end
    initial
    begin
        {i_rst, closed, nc_mode, inh_req, i_alarm, i_prev_alarm} = 12'h800;
        bus = '0;
        pol = 2'h2;
        ack = 1'h0;
        num_errors = 0;
        cmp_count = 0;
        void'($urandom(69834));
        repeat (5) @(posedge i_clock);
        i_rst <= 1'h0;
        rd(`IEL_ADDR_CTRL, v);
        cmp("ctrl", `IEL_CTRL_RESET, v);
        rd(4'hf, v);
        cmp("unmapped", 8'h00, v);
        rd(`IEL_ADDR_INH, v);
        cmp("inh reg", 8'h00, v);
        check_state();
        repeat (16)
        begin
            pol = 2'($urandom);
            ack = 1'($urandom);
            {closed, nc_mode, inh_req, i_alarm, i_prev_alarm} <= 11'($urandom);
            wr(`IEL_ADDR_CTRL, {5'h0, pol, ack});
            check_state();
        end
        {pol, ack, nc_mode, inh_req} = 5'h0;
        wr(`IEL_ADDR_CTRL, 8'h00);
        wr(`IEL_ADDR_MASK, 8'h02);
        check_state();
        wr(`IEL_ADDR_IRQ, 8'h07);
        repeat (3) @(posedge i_clock);
        cmp("irq", 8'h00, irq);
        inh_req <= 1'h1;
        check_state();
        cmp("irq", 8'h01, irq);
        rd(`IEL_ADDR_IRQ, v);
        cmp("irq status", 8'h02, v);
        wr(`IEL_ADDR_MASK, 8'h00);
        repeat (3) @(posedge i_clock);
        cmp("irq masked", 8'h00, irq);
        wr(`IEL_ADDR_IRQ, 8'h02);
        rd(`IEL_ADDR_IRQ, v);
        cmp("irq cleared", 8'h00, v);
        ack = 1'h1;
        wr(`IEL_ADDR_CTRL, 8'h09);
        check_state();
        inh_req <= 1'h0;
        repeat (8) @(posedge i_clock);
        cmp("view", IEL_VIEW_AUTOTEST, view);
        repeat (1000) @(posedge i_clock);
        cmp("view", IEL_VIEW_AUTOTEST, view);
        repeat (1000) @(posedge i_clock);
        #1 cmp("view", IEL_VIEW_MEASURE, view);
        rd(`IEL_ADDR_IRQ, v);
        cmp("irq test", 8'h04, v & 8'h04);
        i_rst <= 1'h1;
        repeat (5) @(posedge i_clock);
        i_rst <= 1'h0;
        #1 cmp("view", IEL_VIEW_MEASURE, view);
        rd(`IEL_ADDR_CTRL, v);
        cmp("ctrl", `IEL_CTRL_RESET, v);
        // breaker patterns, each held across a full processing cycle
        pats = '{7'h0f, 7'h5e, 7'h7f};
        repeat (10) pats.push_back(7'($urandom));
        foreach (pats[k])
        begin
            closed <= pats[k];
            repeat (`IEL_CYCLE_CNT + 8) @(posedge i_clock);
            #1 cmp("inhibit", {5'h0, model_inh(pats[k])}, {5'h0, inhibit});
            rd(`IEL_ADDR_INH, v);
            cmp("inh reg", {5'h0, model_inh(pats[k])}, v);
            rd(`IEL_ADDR_BRK, v);
            cmp("brk reg", {1'h0, pats[k]}, v);
        end
        test_done();
    end
endmodule
bind iel_top iel_top_chk u_iel_top_chk (.i_clock(i_clock), .i_rst(i_rst),
    .i_breakers(i_breakers), .i_inhibit_contact(i_inhibit_contact), .i_alarm(i_alarm),
    .i_prev_alarm(i_prev_alarm), .i_bus(i_bus), .o_rdata(o_rdata), .o_inhibit(o_inhibit),
    .o_injecting(o_injecting), .o_alarm_relay(o_alarm_relay), .o_view(o_view), .o_irq(o_irq));

// ---- dv/iel_top_chk.sv ----
// port assertions for the exclusion logic
`timescale 1ns/100ps
`include "iel_regs.svh"
module iel_top_chk (
    input wire logic               i_clock,
    input wire logic               i_rst,
    input wire iel_pkg::iel_brk_t  i_breakers,
    input wire logic               i_inhibit_contact,
    input wire logic               i_alarm,
    input wire logic               i_prev_alarm,
    input wire iel_pkg::iel_bus_t  i_bus,
    input wire logic [7:0]         o_rdata,
    input wire logic [3:1]         o_inhibit,
    input wire logic               o_injecting,
    input wire logic               o_alarm_relay,
    input wire iel_pkg::iel_view_t o_view,
    input wire logic               o_irq
);
    import iel_pkg::*;
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (i_rst);
    logic       ack_ff;
    logic       int_ff;
    logic [3:1] exp_inh;
    wire  [3:0] f = i_breakers.feeder;
    wire  [2:0] c = i_breakers.coupling;
    assign exp_inh[1] = f[1] & c[0] & f[0];
    assign exp_inh[2] = f[2] & c[1] & (f[1] | (c[0] & f[0]));
    assign exp_inh[3] = f[3] & c[2] & (f[2] | (c[1] & f[1]) | (c[1] & c[0] & f[0]));
    // mirror of the ack and type ctrl bits, ports alone cannot show them
    always_ff @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
        begin
            ack_ff <= 1'h0;
            int_ff <= 1'h0;
        end
        else if (i_bus.wr && i_bus.addr == `IEL_ADDR_CTRL)
        begin
            ack_ff <= i_bus.wdata[`IEL_CTRL_ACK_BIT];
            int_ff <= i_bus.wdata[`IEL_CTRL_TYPE_BIT];
        end
    end
    // two sync flops, snapshot, update: pins lead the seen change by four edges
    a_dev2_inhibit:
        assert property ($changed(o_inhibit) |-> o_inhibit[1] == $past(exp_inh[1], 4))
        else $error("dev2 inhibit wrong");
    a_dev3_inhibit:
        assert property ($changed(o_inhibit) |-> o_inhibit[2] == $past(exp_inh[2], 4))
        else $error("dev3 inhibit wrong");
    a_dev4_inhibit:
        assert property ($changed(o_inhibit) |-> o_inhibit[3] == $past(exp_inh[3], 4))
        else $error("dev4 inhibit wrong");
    a_view_disabled:
        assert property (!o_injecting [*3] |-> o_view == IEL_VIEW_DISABLED)
        else $error("disabled view missing");
    a_ext_return:
        assert property ($rose(o_injecting) && !int_ff |-> ##[0:2] o_view == IEL_VIEW_MEASURE)
        else $error("external return wrong");
    a_int_autotest:
        assert property ($rose(o_injecting) && int_ff |-> ##[0:2] o_view == IEL_VIEW_AUTOTEST)
        else $error("no auto-test on re-enable");
    a_relay_ack:
        assert property ((ack_ff && !o_injecting) [*3] |-> o_alarm_relay)
        else $error("relay feedback missing");
    a_reset_outs:
        assert property ($fell(i_rst) |-> o_inhibit == 3'h0 && !o_irq
            && o_view == IEL_VIEW_MEASURE) else $error("outputs not cleared");
endmodule

// ---- src/iel_pkg.sv ----
// types for the injection exclusion logic
package iel_pkg;
    typedef enum logic [1:0] {
        IEL_POL_NO  = 2'b00,
        IEL_POL_NC  = 2'b01,
        IEL_POL_OFF = 2'b10
    } iel_pol_t;

    typedef enum logic [1:0] {
        IEL_VIEW_MEASURE  = 2'b00,
        IEL_VIEW_DISABLED = 2'b01,
        IEL_VIEW_AUTOTEST = 2'b10
    } iel_view_t;

    typedef struct packed {
        logic [2:0] coupling;
        logic [3:0] feeder;
    } iel_brk_t;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } iel_bus_t;
endpackage

// ---- src/iel_regs.svh ----
// constants for the injection exclusion logic
`ifndef IEL_REGS_SVH
`define IEL_REGS_SVH

`define IEL_CLK_HZ          250000000
// processing cycle, far inside the 0.1 s ceiling
`define IEL_CYCLE_US        8
`define IEL_CYCLE_CNT       ((`IEL_CLK_HZ / 1000000) * `IEL_CYCLE_US)
`define IEL_TEST_US         8
`define IEL_TEST_CNT        ((`IEL_CLK_HZ / 1000000) * `IEL_TEST_US)
`define IEL_N_FEEDER        4
`define IEL_N_COUPLING      3
`define IEL_N_DEVICE        4

`define IEL_ADDR_CTRL       4'h0
`define IEL_ADDR_BRK        4'h1
`define IEL_ADDR_INH        4'h2
`define IEL_ADDR_STAT       4'h3
`define IEL_ADDR_IRQ        4'h4
`define IEL_ADDR_MASK       4'h5

`define IEL_CTRL_ACK_BIT    0
`define IEL_CTRL_POL_LSB    1
`define IEL_CTRL_TYPE_BIT   3
// polarity off at reset: contact ignored until configured
`define IEL_CTRL_RESET      8'h04

`define IEL_IRQ_CHANGE_BIT  0
`define IEL_IRQ_INHIB_BIT   1
`define IEL_IRQ_TEST_BIT    2
`define IEL_IRQ_W           3

`endif

// ---- src/iel_sync.sv ----
// two-flop synchroniser, one per bit
`timescale 1ns/100ps
module iel_sync #(
    parameter int W = 1
) (
    input  wire logic         i_clock,
    input  wire logic         i_rst,
    input  wire logic [W-1:0] i_async,
    output logic      [W-1:0] o_sync
);
    logic [W-1:0] meta_ff;
    logic [W-1:0] sync_ff;

    always_ff @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
        begin
            meta_ff <= '0;
            sync_ff <= '0;
        end
        else
        begin
            meta_ff <= i_async;
            sync_ff <= meta_ff;
        end
    end

    assign o_sync = sync_ff;
endmodule

// ---- src/iel_top.sv ----
// priority exclusion logic with monitored-device inhibit handling
//
// How it works
// [RULE_01] one input per feeder and coupling breaker
// [RULE_02] inhibit outputs: one fewer than devices
// [RULE_03] full update each cycle, under 0.1 s
// [RULE_04] device one never inhibited, always injects
// [RULE_05] device two: feeder2, coupling1, feeder1 closed
// [RULE_06] device three: F3 C2 (F2 or C1 F1)
// [RULE_07] device four: F4 C3 (F3 or C2F2 or C2C1F1)
// [RULE_08] closed is one; inhibit is one
// [RULE_09] disabled view overrides any measurement view
// [RULE_10] internal type re-enable runs auto-test first
// [RULE_11] external type re-enable returns directly
// [RULE_12] ack on: alarm relay while injection disabled
// [RULE_13] ack setting on or off, resets off
// [RULE_14] inhibit input polarity: open, closed, off
// [RULE_15] sample once per tick, update together
//
// The implementer's own choices: the strobed register port and the register offsets.
`timescale 1ns/100ps
`include "iel_regs.svh"
module iel_top (
    input  wire logic                  i_clock,
    input  wire logic                  i_rst,
    input  wire iel_pkg::iel_brk_t     i_breakers,
    input  wire logic                  i_inhibit_contact,
    input  wire logic                  i_alarm,
    input  wire logic                  i_prev_alarm,
    input  wire iel_pkg::iel_bus_t     i_bus,
    output logic [7:0]                 o_rdata,
    output logic [`IEL_N_DEVICE-1:1]   o_inhibit,
    output logic                       o_injecting,
    output logic                       o_alarm_relay,
    output iel_pkg::iel_view_t         o_view,
    output logic                       o_irq
);
    import iel_pkg::*;

    localparam int CYC_W  = $clog2(`IEL_CYCLE_CNT);
    localparam int TEST_W = $clog2(`IEL_TEST_CNT + 1);
    localparam logic [CYC_W-1:0]  CYC_LAST  = CYC_W'(`IEL_CYCLE_CNT - 1);
    localparam logic [TEST_W-1:0] TEST_LAST = TEST_W'(`IEL_TEST_CNT - 1);

    // pins: breaker contacts and inhibit contact cross in through two flops
    iel_brk_t brk_sync;
    logic     contact_sync;

    iel_sync #(.W(`IEL_N_FEEDER + `IEL_N_COUPLING + 1)) u_sync (
        .i_clock (i_clock),
        .i_rst   (i_rst),
        .i_async ({i_breakers, i_inhibit_contact}),
        .o_sync  ({brk_sync, contact_sync})
    );

    // processing tick
    logic [CYC_W-1:0] cyc_ff;
    logic [CYC_W-1:0] nxt_cyc;
    wire              tick = (cyc_ff == CYC_LAST);

    assign nxt_cyc = tick ? '0 : cyc_ff + 1'b1;

    always_ff @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
            cyc_ff <= '0;
        else
            cyc_ff <= nxt_cyc; // RULE_03
    end

    // breaker snapshot taken once per tick
    iel_brk_t brk_ff;

    always_ff @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
            brk_ff <= '0;
        else if (tick)
            brk_ff <= brk_sync; // RULE_15 RULE_01
    end

    // path equations, closed == 1
    wire [3:0] f = brk_ff.feeder;   // RULE_08
    wire [2:0] c = brk_ff.coupling;
    wire       inh2 = f[1] & c[0] & f[0]; // RULE_05
    wire       inh3 = f[2] & c[1] & (f[1] | (c[0] & f[0])); // RULE_06
    wire       inh4 = f[3] & c[2] & (f[2] | (c[1] & f[1]) | (c[1] & c[0] & f[0])); // RULE_07

    // device one has no inhibit output at all
    logic [`IEL_N_DEVICE-1:1] inh_ff;
    logic [`IEL_N_DEVICE-1:1] nxt_inh;
    logic                     upd_ff;

    assign nxt_inh = {inh4, inh3, inh2}; // RULE_02 RULE_04

    // snapshot at tick, outputs on the next edge, all at once
    always_ff @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
        begin
            upd_ff <= 1'b0;
            inh_ff <= '0;
        end
        else
        begin
            upd_ff <= tick;
            if (upd_ff)
                inh_ff <= nxt_inh; // RULE_15 RULE_03
        end
    end

    // control register
    logic [7:0] ctrl_ff;
    wire        ack_on   = ctrl_ff[`IEL_CTRL_ACK_BIT];
    wire [1:0]  pol_raw  = ctrl_ff[`IEL_CTRL_POL_LSB +: 2];
    wire        type_int = ctrl_ff[`IEL_CTRL_TYPE_BIT];
    iel_pol_t   pol;

    // unknown polarity code acts as ignored input
    assign pol = (pol_raw == IEL_POL_NO) ? IEL_POL_NO :
                 (pol_raw == IEL_POL_NC) ? IEL_POL_NC : IEL_POL_OFF;

    // bus decode
    wire wr_ctrl = i_bus.wr & (i_bus.addr == `IEL_ADDR_CTRL);
    wire wr_irq  = i_bus.wr & (i_bus.addr == `IEL_ADDR_IRQ);
    wire wr_mask = i_bus.wr & (i_bus.addr == `IEL_ADDR_MASK);

    // ack bit is a single flop bit, only on/off storable
    wire [7:0] ctrl_wmask = 8'h0f;

    always_ff @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
            ctrl_ff <= `IEL_CTRL_RESET; // RULE_13
        else if (wr_ctrl)
            ctrl_ff <= i_bus.wdata & ctrl_wmask; // RULE_13
    end

    // local inhibit request from the contact
    logic disabled;

    always_comb
    begin
        unique case (pol)
            IEL_POL_NO:  disabled = contact_sync;  // RULE_14
            IEL_POL_NC:  disabled = ~contact_sync; // RULE_14
            IEL_POL_OFF: disabled = 1'b0;          // RULE_14
            default:     disabled = 1'b0;
        endcase
    end

    // view state machine
    logic [TEST_W-1:0] test_ff;
    iel_view_t         view_ff;
    iel_view_t         nxt_view;
    logic              test_done;

    assign test_done = (view_ff == IEL_VIEW_AUTOTEST) && (test_ff == TEST_LAST);

    always_comb
    begin
        nxt_view = view_ff;
        unique case (view_ff)
            IEL_VIEW_MEASURE:
                if (disabled)
                    nxt_view = IEL_VIEW_DISABLED; // RULE_09
            IEL_VIEW_DISABLED:
                if (!disabled)
                    nxt_view = type_int ? IEL_VIEW_AUTOTEST // RULE_10
                                        : IEL_VIEW_MEASURE; // RULE_11
            IEL_VIEW_AUTOTEST:
                if (disabled)
                    nxt_view = IEL_VIEW_DISABLED; // RULE_09
                else if (test_done)
                    nxt_view = IEL_VIEW_MEASURE; // RULE_10
            default:
                nxt_view = IEL_VIEW_MEASURE;
        endcase
    end

    // test timer restarts on every entry into auto-test
    logic [TEST_W-1:0] nxt_test;
    wire               test_stay = (nxt_view == IEL_VIEW_AUTOTEST) &&
                                   (view_ff == IEL_VIEW_AUTOTEST);

    assign nxt_test = test_stay ? test_ff + 1'b1 : '0;

    always_ff @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
            view_ff <= IEL_VIEW_MEASURE;
        else
            view_ff <= nxt_view;
    end

    always_ff @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
            test_ff <= '0;
        else
            test_ff <= nxt_test;
    end

    // alarm relay: measurement alarm, or inhibit feedback when ack on
    wire relay_nxt = i_alarm | (ack_on & disabled); // RULE_12

    // interrupts: change of inhibit vector, entry into disabled, test done
    logic [`IEL_IRQ_W-1:0] irq_ff;
    logic [`IEL_IRQ_W-1:0] mask_ff;
    logic [`IEL_IRQ_W-1:0] irq_set;
    logic [`IEL_IRQ_W-1:0] irq_clr;

    assign irq_set[`IEL_IRQ_CHANGE_BIT] = upd_ff & (nxt_inh != inh_ff);
    assign irq_set[`IEL_IRQ_INHIB_BIT]  = (nxt_view == IEL_VIEW_DISABLED) &
                                          (view_ff != IEL_VIEW_DISABLED);
    assign irq_set[`IEL_IRQ_TEST_BIT]   = test_done & ~disabled;
    assign irq_clr = wr_irq ? i_bus.wdata[`IEL_IRQ_W-1:0] : '0;

    // per-event sticky bit; set wins over a same-cycle clear
    logic [`IEL_IRQ_W-1:0] nxt_irq;

    for (genvar b = 0; b < `IEL_IRQ_W; b++)
    begin : g_irq
        assign nxt_irq[b] = irq_set[b] | (irq_ff[b] & ~irq_clr[b]);
    end

    always_ff @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
            irq_ff <= '0;
        else
            irq_ff <= nxt_irq;
    end

    always_ff @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
            mask_ff <= '0;
        else if (wr_mask)
            mask_ff <= i_bus.wdata[`IEL_IRQ_W-1:0];
    end

    // read mux; unmapped addresses read zero
    logic [7:0] rd_mux;

    always_comb
    begin
        unique case (i_bus.addr)
            `IEL_ADDR_CTRL: rd_mux = ctrl_ff;
            `IEL_ADDR_BRK:  rd_mux = {1'b0, brk_ff};
            `IEL_ADDR_INH:  rd_mux = {5'h00, inh_ff};
            `IEL_ADDR_STAT: rd_mux = {3'h0, i_prev_alarm, disabled, relay_nxt, view_ff};
            `IEL_ADDR_IRQ:  rd_mux = {5'h00, irq_ff};
            `IEL_ADDR_MASK: rd_mux = {5'h00, mask_ff};
            default:        rd_mux = 8'h00;
        endcase
    end

    // registered outputs, one short process each
    wire [7:0]               nxt_rdata   = i_bus.rd ? rd_mux : 8'h00;
    wire [`IEL_N_DEVICE-1:1] nxt_out_inh = upd_ff ? nxt_inh : inh_ff;
    wire                     nxt_irq_out = |(nxt_irq & mask_ff);

    always_ff @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
            o_rdata <= 8'h00;
        else
            o_rdata <= nxt_rdata;
    end

    // all three inhibit outputs move on the same edge
    always_ff @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
            o_inhibit <= '0; // RULE_15
        else
            o_inhibit <= nxt_out_inh; // RULE_15
    end

    // reset value lets the device inject until told otherwise
    always_ff @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
            o_injecting <= 1'b1;
        else
            o_injecting <= ~disabled;
    end

    always_ff @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
            o_alarm_relay <= 1'b0;
        else
            o_alarm_relay <= relay_nxt; // RULE_12
    end

    always_ff @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
            o_view <= IEL_VIEW_MEASURE;
        else
            o_view <= nxt_view; // RULE_09
    end

    always_ff @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
            o_irq <= 1'b0;
        else
            o_irq <= nxt_irq_out;
    end
endmodule
